/* ckg_cfg_regs.sv */
// configuration bank 00h-07h of the clock generator, byte-stream access
`timescale 1ns/1ps
`default_nettype none
module ckg_cfg_regs
  import ckg_pkg::*;
#(
  parameter int NBYTES = CKG_NBYTES
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  nrst,
  // frame control from the serial engine
  input  wire logic  frame_start,
  input  wire logic  frame_read,
  input  wire logic  frame_stop,
  // received bytes
  input  wire logic        rx_valid,
  input  wire logic  [7:0] rx_byte,
  output logic             rx_ack_r,
  // transmitted bytes
  input  wire logic        tx_req,
  output logic             tx_valid_r,
  output logic       [7:0] tx_byte_r,
  // bus address and general control
  output logic       [7:0] bus_addr_r,
  output logic             memory_programmed,
  output logic             memory_write_lock,
  output logic             first_loop_spread_enable,
  output logic             third_loop_source_select,
  output logic       [7:0] variant_code,
  // third loop reference and feedback dividers
  output logic             third_loop_predivide_by_one,
  output logic             third_loop_predivide_by_two,
  output logic       [5:0] third_loop_ref_divider,
  output logic             ref_divider_ok_r,
  output logic      [10:0] third_loop_fb_divider,
  output logic             fb_divider_ok_r,
  // third loop filter and pump
  output logic      [10:0] filter_r_total_r,
  output logic             out_divider_three_source,
  output logic       [4:0] pump_weight_r,
  output logic       [4:0] pump_divisor_r,
  output logic       [4:0] third_loop_iref_ua_r,
  // first loop control and divider five
  output logic             first_loop_ref_doubler,
  output logic       [7:0] first_loop_iref_tenth_ua_r,
  output logic             first_loop_channel_two_enable,
  output logic             first_loop_extra_pole_enable,
  output logic       [3:0] out_divider_five_code,
  output logic       [5:0] out_divider_five_ratio_r
);

  if (NBYTES != CKG_NBYTES) begin : g_check
    $error("ckg_cfg_regs: bank holds exactly eight bytes");
  end

  ckg_state_t  state_r, state_nxt;
  logic [7:0]  ptr_r, ptr_nxt;
  logic [7:0]  count_r, count_nxt;
  logic [7:0]  remain_r, remain_nxt;
  logic        pend_r, pend_nxt;
  logic        pend_cnt_r, pend_cnt_nxt;
  logic        pend_oor_r, pend_oor_nxt;
  logic        rx_ack_nxt;
  logic        tx_valid_nxt;
  logic [7:0]  tx_byte_nxt;
  logic        mem_we;
  logic        mem_re;
  logic        ptr_in_range;
  logic [7:0]  mem_rdata;
  logic [63:0] bytes;
  logic [7:0]  b0, b3, b5, b6, b7;

  ckg_regmem #(
    .DEPTH (CKG_NBYTES),
    .AW    (CKG_ADDR_W),
    .INIT  (CKG_RESET_IMAGE)
  ) u_mem (
    .clk     (clk),
    .nrst    (nrst),
    .we      (mem_we),
    .waddr   (ptr_r[2:0]),
    .wdata   (rx_byte),
    .re      (mem_re),
    .raddr   (ptr_r[2:0]),
    .rdata_r (mem_rdata),
    .bytes_r (bytes)
  );

  assign b0 = bytes[CKG_OFS_GENERAL_CONTROL*8 +: 8];
  assign b3 = bytes[CKG_OFS_PLL3_REF_DIV*8 +: 8];
  assign b5 = bytes[CKG_OFS_PLL3_FILTER_FB_HIGH*8 +: 8];
  assign b6 = bytes[CKG_OFS_PLL3_PUMP_DIV3_SRC*8 +: 8];
  assign b7 = bytes[CKG_OFS_PLL1_CTRL_DIV5*8 +: 8];

  // field outputs taken straight from the register flops
  assign memory_programmed        = b0[CKG_GEN_PROGRAMMED_BIT];
  assign memory_write_lock        = b0[CKG_GEN_LOCK_BIT];
  assign first_loop_spread_enable = b0[CKG_GEN_SPREAD_BIT];
  assign third_loop_source_select = b0[CKG_GEN_SOURCE_BIT];
  assign variant_code = bytes[CKG_OFS_VARIANT_CODE*8 +: 8];
  assign third_loop_predivide_by_one = b3[CKG_REF_PREDIV1_BIT];
  assign third_loop_predivide_by_two = b3[CKG_REF_PREDIV2_BIT];
  assign third_loop_ref_divider = b3[CKG_REF_DIV_LO +: 6];
  assign third_loop_fb_divider =
    {b5[CKG_FB_HIGH_LO +: 3], bytes[CKG_OFS_PLL3_FB_LOW*8 +: 8]};
  assign out_divider_three_source = b6[CKG_PMP_DIV3_SRC_BIT];
  assign first_loop_ref_doubler   = b7[CKG_P1_DOUBLER_BIT];
  assign first_loop_channel_two_enable = b7[CKG_P1_CH2_BIT];
  assign first_loop_extra_pole_enable  = b7[CKG_P1_POLE_BIT];
  assign out_divider_five_code = b7[CKG_DIV5_LO +: 4];

  assign ptr_in_range = (ptr_r[7:CKG_ADDR_W] == '0);
  // bytes past 07h belong to other banks: acknowledged, not stored
  assign mem_we = (state_r == CKG_DATA) && rx_valid && ptr_in_range;
  assign mem_re = (state_r == CKG_SEND_DAT) && tx_req;

  // frame sequencer
  always_comb begin
    state_nxt    = state_r;
    ptr_nxt      = ptr_r;
    count_nxt    = count_r;
    remain_nxt   = remain_r;
    pend_nxt     = 1'b0;
    pend_cnt_nxt = pend_cnt_r;
    pend_oor_nxt = pend_oor_r;
    rx_ack_nxt   = 1'b0;
    case (state_r)
      CKG_IDLE: begin
      end
      CKG_INDEX: begin
        if (rx_valid) begin
          ptr_nxt    = rx_byte;
          rx_ack_nxt = 1'b1;
          state_nxt  = CKG_COUNT;
        end
      end
      CKG_COUNT: begin
        if (rx_valid) begin
          count_nxt  = rx_byte;
          remain_nxt = rx_byte;
          rx_ack_nxt = 1'b1;
          state_nxt  = (rx_byte == 8'h00) ? CKG_IDLE : CKG_DATA;
        end
      end
      CKG_DATA: begin
        if (rx_valid) begin
          rx_ack_nxt = 1'b1;
          ptr_nxt    = ptr_r + 8'h01;
          remain_nxt = remain_r - 8'h01;
          if (remain_r == 8'h01) begin
            state_nxt = CKG_IDLE;
          end
        end
      end
      CKG_SEND_CNT: begin
        if (tx_req) begin
          pend_nxt     = 1'b1;
          pend_cnt_nxt = 1'b1;
          state_nxt    = CKG_SEND_DAT;
        end
      end
      CKG_SEND_DAT: begin
        if (tx_req) begin
          pend_nxt     = 1'b1;
          pend_cnt_nxt = 1'b0;
          pend_oor_nxt = !ptr_in_range;
          ptr_nxt      = ptr_r + 8'h01;
        end
      end
      default: state_nxt = CKG_IDLE;
    endcase
    if (frame_start) begin
      state_nxt = frame_read ? CKG_SEND_CNT : CKG_INDEX;
    end
    if (frame_stop) begin
      state_nxt = CKG_IDLE;
    end
  end

  // answer stage: count first, then data; unmapped bytes read zero
  always_comb begin
    tx_valid_nxt = pend_r;
    tx_byte_nxt  = tx_byte_r;
    if (pend_r) begin
      if (pend_cnt_r) begin
        tx_byte_nxt = count_r;
      end else if (pend_oor_r) begin
        tx_byte_nxt = 8'h00;
      end else begin
        tx_byte_nxt = mem_rdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r    <= CKG_IDLE;
      ptr_r      <= 8'h00;
      count_r    <= CKG_COUNT_RESET;
      remain_r   <= 8'h00;
      pend_r     <= 1'b0;
      pend_cnt_r <= 1'b0;
      pend_oor_r <= 1'b0;
      rx_ack_r   <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_byte_r  <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      ptr_r      <= ptr_nxt;
      count_r    <= count_nxt;
      remain_r   <= remain_nxt;
      pend_r     <= pend_nxt;
      pend_cnt_r <= pend_cnt_nxt;
      pend_oor_r <= pend_oor_nxt;
      rx_ack_r   <= rx_ack_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_byte_r  <= tx_byte_nxt;
    end
  end

  // decoded settings
  logic [7:0]  bus_addr_nxt;
  logic        ref_ok_nxt;
  logic        fb_ok_nxt;
  logic [10:0] filter_nxt;
  logic [4:0]  weight_nxt;
  logic [4:0]  divisor_nxt;
  logic [4:0]  iref3_nxt;
  logic [7:0]  iref1_nxt;
  logic [5:0]  div5_nxt;
  logic [4:0]  raw_weight;

  always_comb begin
    bus_addr_nxt = ckg_bus_addr(b0[CKG_GEN_ADDR_SEL_LO +: 2]);
    ref_ok_nxt   = (b3[CKG_REF_DIV_LO +: 6] >= CKG_REF_DIV_MIN);
    fb_ok_nxt    = (third_loop_fb_divider >= CKG_FB_DIV_MIN);
    filter_nxt   = ckg_filter_r(b5[CKG_FLT_R6K_BIT +: 5]);
    raw_weight   = {1'b0, b6[CKG_PMP_WEIGHT_LO +: 4]};
    // doubled bias doubles the weighted sum
    weight_nxt   = b6[CKG_PMP_BIAS_BIT] ? {raw_weight[3:0], 1'b0}
                                        : raw_weight;
    divisor_nxt  = (b6[CKG_PMP_DIV24_BIT] ? 5'h18 : 5'h00)
                 + (b6[CKG_PMP_DIV3_BIT] ? 5'h03 : 5'h00);
    iref3_nxt    = b6[CKG_PMP_BIAS_BIT] ? CKG_IREF3_HIGH
                                        : CKG_IREF3_LOW;
    iref1_nxt    = b7[CKG_P1_BIAS_BIT] ? CKG_IREF1_HIGH
                                       : CKG_IREF1_LOW;
    div5_nxt     = ckg_div5(b7[CKG_DIV5_LO +: 4]);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus_addr_r                 <= CKG_BUS_ADDR_BASE;
      ref_divider_ok_r           <= 1'b0;
      fb_divider_ok_r            <= 1'b0;
      filter_r_total_r           <= 11'h000;
      pump_weight_r              <= 5'h00;
      pump_divisor_r             <= 5'h00;
      third_loop_iref_ua_r       <= CKG_IREF3_LOW;
      first_loop_iref_tenth_ua_r <= CKG_IREF1_LOW;
      out_divider_five_ratio_r   <= 6'h00;
    end else begin
      bus_addr_r                 <= bus_addr_nxt;
      ref_divider_ok_r           <= ref_ok_nxt;
      fb_divider_ok_r            <= fb_ok_nxt;
      filter_r_total_r           <= filter_nxt;
      pump_weight_r              <= weight_nxt;
      pump_divisor_r             <= divisor_nxt;
      third_loop_iref_ua_r       <= iref3_nxt;
      first_loop_iref_tenth_ua_r <= iref1_nxt;
      out_divider_five_ratio_r   <= div5_nxt;
    end
  end

  // checks
  a_write_ack: assert property (@(posedge clk) disable iff (!nrst)
    (rx_valid && !frame_start && !frame_stop && state_r != CKG_IDLE
     && state_r != CKG_SEND_CNT && state_r != CKG_SEND_DAT)
    |=> rx_ack_r) else $error("received byte not acknowledged");
  a_count_first: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == CKG_SEND_CNT && tx_req && !frame_start && !frame_stop)
    |-> ##2 (tx_valid_r && tx_byte_r == $past(count_r, 2)))
    else $error("count not sent first");
  a_addr_select: assert property (@(posedge clk) disable iff (!nrst)
    (b0[6:5] == 2'h3) |=> (bus_addr_r == 8'hd6 || $past(b0[6:5]) != 2'h3))
    else $error("bus address select wrong");
  a_spread_write: assert property (@(posedge clk) disable iff (!nrst)
    (mem_we && ptr_r == 8'h00)
    |=> (first_loop_spread_enable == $past(rx_byte[4])))
    else $error("spread enable not stored");
  a_reset_image: assert property (@(posedge clk) disable iff (!nrst)
    !$past(nrst) |-> (third_loop_ref_divider == 6'h1a
      && third_loop_fb_divider == 11'h1e0 && b7 == 8'h23))
    else $error("reset image wrong");
  a_div5_default: assert property (@(posedge clk) disable iff (!nrst)
    (out_divider_five_code == 4'h3) ##1 (out_divider_five_code == 4'h3)
    |-> out_divider_five_ratio_r == 6'h0a)
    else $error("divider five ratio wrong");
  a_filter_6k: assert property (@(posedge clk) disable iff (!nrst)
    b5[CKG_FLT_R6K_BIT] |=> filter_r_total_r == 11'h03c)
    else $error("6k filter not exclusive");
  a_ref_min: assert property (@(posedge clk) disable iff (!nrst)
    (third_loop_ref_divider < 6'h03) |=> !ref_divider_ok_r)
    else $error("reference divider below 3 accepted");
  a_pump_iref: assert property (@(posedge clk) disable iff (!nrst)
    b6[0] |=> (third_loop_iref_ua_r == 5'h14 && pump_weight_r[0] == 1'b0))
    else $error("pump bias select wrong");
  c_write_done: cover property (@(posedge clk) disable iff (!nrst)
    state_r == CKG_DATA && rx_valid && remain_r == 8'h01);
  c_read_two: cover property (@(posedge clk) disable iff (!nrst)
    tx_valid_r ##1 !tx_valid_r ##1 tx_valid_r);
  c_div5_max: cover property (@(posedge clk) disable iff (!nrst)
    out_divider_five_ratio_r == 6'h32);

endmodule : ckg_cfg_regs
`default_nettype wire

/* ckg_pkg.sv */
// package: offsets, field positions, reset image and decode functions
package ckg_pkg;

  // bank geometry
  localparam int          CKG_NBYTES   = 8;
  localparam int          CKG_ADDR_W   = 3;
  localparam int          CKG_BYTE_W   = 8;

  // register offsets
  localparam logic [2:0]  CKG_OFS_GENERAL_CONTROL     = 3'h0;
  localparam logic [2:0]  CKG_OFS_VARIANT_CODE        = 3'h1;
  localparam logic [2:0]  CKG_OFS_CRYSTAL_LOAD        = 3'h2;
  localparam logic [2:0]  CKG_OFS_PLL3_REF_DIV        = 3'h3;
  localparam logic [2:0]  CKG_OFS_PLL3_FB_LOW         = 3'h4;
  localparam logic [2:0]  CKG_OFS_PLL3_FILTER_FB_HIGH = 3'h5;
  localparam logic [2:0]  CKG_OFS_PLL3_PUMP_DIV3_SRC  = 3'h6;
  localparam logic [2:0]  CKG_OFS_PLL1_CTRL_DIV5      = 3'h7;

  // general_control fields
  localparam int          CKG_GEN_PROGRAMMED_BIT = 7;
  localparam int          CKG_GEN_ADDR_SEL_LO    = 5;
  localparam int          CKG_GEN_SPREAD_BIT     = 4;
  localparam int          CKG_GEN_SOURCE_BIT     = 2;
  localparam int          CKG_GEN_LOCK_BIT       = 0;
  // pll3_reference_divider fields
  localparam int          CKG_REF_PREDIV1_BIT    = 7;
  localparam int          CKG_REF_PREDIV2_BIT    = 6;
  localparam int          CKG_REF_DIV_LO         = 0;
  // pll3_filter_and_feedback_high fields
  localparam int          CKG_FLT_R_LO           = 4;
  localparam int          CKG_FLT_R6K_BIT        = 3;
  localparam int          CKG_FB_HIGH_LO         = 0;
  // pll3_pump_and_div3_source fields
  localparam int          CKG_PMP_DIV3_SRC_BIT   = 7;
  localparam int          CKG_PMP_WEIGHT_LO      = 3;
  localparam int          CKG_PMP_DIV24_BIT      = 2;
  localparam int          CKG_PMP_DIV3_BIT       = 1;
  localparam int          CKG_PMP_BIAS_BIT       = 0;
  // pll1_control_and_div5 fields
  localparam int          CKG_P1_DOUBLER_BIT     = 7;
  localparam int          CKG_P1_BIAS_BIT        = 6;
  localparam int          CKG_P1_CH2_BIT         = 5;
  localparam int          CKG_P1_POLE_BIT        = 4;
  localparam int          CKG_DIV5_LO            = 0;

  // values after reset, byte 0 in the low lanes
  localparam logic [63:0] CKG_RESET_IMAGE =
    {8'h23, 8'h6c, 8'h11, 8'he0, 8'h1a, 8'h11, 8'h00, 8'h00};
  localparam logic [7:0]  CKG_COUNT_RESET = 8'h08;

  // bus address and divider limits
  localparam logic [7:0]  CKG_BUS_ADDR_BASE = 8'hd0;
  localparam logic [5:0]  CKG_REF_DIV_MIN   = 6'h03;
  localparam logic [10:0] CKG_FB_DIV_MIN    = 11'h00c;
  // filter resistances in units of 100 ohm
  localparam logic [10:0] CKG_R_100K = 11'h3e8;
  localparam logic [10:0] CKG_R_50K  = 11'h1f4;
  localparam logic [10:0] CKG_R_25K  = 11'h0fa;
  localparam logic [10:0] CKG_R_12K5 = 11'h07d;
  localparam logic [10:0] CKG_R_6K   = 11'h03c;
  // pump reference currents: pll3 in uA, pll1 in tenths of uA
  localparam logic [4:0]  CKG_IREF3_LOW  = 5'h0a;
  localparam logic [4:0]  CKG_IREF3_HIGH = 5'h14;
  localparam logic [7:0]  CKG_IREF1_LOW  = 8'h6c;
  localparam logic [7:0]  CKG_IREF1_HIGH = 8'hd8;
  // cycles from read request to data strobe
  localparam int          CKG_TX_LAT = 2;

  typedef enum logic [2:0] {
    CKG_IDLE     = 3'b000,
    CKG_INDEX    = 3'b001,
    CKG_COUNT    = 3'b011,
    CKG_DATA     = 3'b010,
    CKG_SEND_CNT = 3'b110,
    CKG_SEND_DAT = 3'b111
  } ckg_state_t;

  function automatic logic [7:0] ckg_bus_addr(input logic [1:0] sel);
    ckg_bus_addr = CKG_BUS_ADDR_BASE | {5'h00, sel, 1'b0};
  endfunction : ckg_bus_addr

  function automatic logic [5:0] ckg_div5(input logic [3:0] code);
    logic [5:0]  a;
    logic [5:0]  b;
    logic [11:0] p;
    case (code[3:2])
      2'h0:    a = 6'h01;
      2'h1:    a = 6'h02;
      2'h2:    a = 6'h04;
      default: a = 6'h05;
    endcase
    case (code[1:0])
      2'h0:    b = 6'h01;
      2'h1:    b = 6'h03;
      2'h2:    b = 6'h05;
      default: b = 6'h0a;
    endcase
    p = a * b;
    ckg_div5 = p[5:0];
  endfunction : ckg_div5

  function automatic logic [10:0] ckg_filter_r(input logic [4:0] bits);
    logic [10:0] s;
    s = 11'h000;
    if (bits[4]) s = s + CKG_R_100K;
    if (bits[3]) s = s + CKG_R_50K;
    if (bits[2]) s = s + CKG_R_25K;
    if (bits[1]) s = s + CKG_R_12K5;
    // the 6k setting replaces the series chain
    if (bits[0]) s = CKG_R_6K;
    ckg_filter_r = s;
  endfunction : ckg_filter_r

endpackage : ckg_pkg

/* ckg_regmem.sv */
// byte register file with reset image and registered read port
`timescale 1ns/1ps
`default_nettype none
module ckg_regmem #(
  parameter int              DEPTH = 8,
  parameter int              AW    = 3,
  parameter logic [63:0]     INIT  = 64'h0
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // read port
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata_r,
  // whole contents
  output logic [DEPTH*8-1:0] bytes_r
);

  logic [DEPTH*8-1:0] bytes_nxt;
  logic [7:0]         rdata_nxt;

  if (DEPTH * 8 != 64 || (1 << AW) < DEPTH) begin : g_check
    $error("ckg_regmem: DEPTH and AW do not fit the reset image");
  end

  always_comb begin
    bytes_nxt = bytes_r;
    rdata_nxt = rdata_r;
    if (we) begin
      bytes_nxt[waddr*8 +: 8] = wdata;
    end
    if (re) begin
      rdata_nxt = bytes_r[raddr*8 +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bytes_r <= INIT;
      rdata_r <= 8'h00;
    end else begin
      bytes_r <= bytes_nxt;
      rdata_r <= rdata_nxt;
    end
  end

endmodule : ckg_regmem
`default_nettype wire

/* ckg_host_model.sv */
// serial engine side model: frames, byte strobes and read requests
`timescale 1ns/1ps
`default_nettype none
module ckg_host_model (
  // clock
  input  wire logic       clk,
  // answers from the bank
  input  wire logic       rx_ack_r,
  input  wire logic       tx_valid_r,
  input  wire logic [7:0] tx_byte_r,
  // requests to the bank
  output logic            frame_start,
  output logic            frame_read,
  output logic            frame_stop,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic            tx_req
);
  logic [15:0] ack_seen;
  logic [7:0]  rd [16];

  initial begin
    {frame_start, frame_read, frame_stop, rx_valid, tx_req} = 5'h00;
    rx_byte = 8'h00;
  end

  // index, count, data back to back; st=0 sends bytes outside a frame
  task automatic write_frame(input logic st, sp, input logic [7:0] b [10],
                             input int nb);
    ack_seen = '0;
    if (st) begin
      @(negedge clk);
      frame_start = 1'b1;
      frame_read  = 1'b0;
    end
    for (int k = 0; k <= nb; k++) begin
      @(negedge clk);
      frame_start = 1'b0;
      if (k > 0) ack_seen[k-1] = rx_ack_r;
      rx_valid = k < nb;
      // released data line shows the inverse, not the stale byte
      rx_byte = (k < nb) ? b[k] : ~rx_byte;
    end
    if (sp) begin
      frame_stop = 1'b1;
      @(negedge clk);
      frame_stop = 1'b0;
    end
  endtask : write_frame

  // index write, repeated start for read, n requests, then stop
  task automatic read_frame(input logic [7:0] idx, input int n);
    logic [7:0] b [10];
    b = '{default: 8'h00};
    b[0] = idx;
    write_frame(1'b1, 1'b0, b, 1);
    @(negedge clk);
    frame_start = 1'b1;
    frame_read  = 1'b1;
    for (int k = 0; k <= n + 1; k++) begin
      @(negedge clk);
      frame_start = 1'b0;
      if (k > 1) rd[k-2] = tx_valid_r ? tx_byte_r : 8'hxx;
      tx_req = k < n;
    end
    frame_stop = 1'b1;
    @(negedge clk);
    frame_stop = 1'b0;
  endtask : read_frame
endmodule : ckg_host_model
`default_nettype wire

/* test_ckg_cfg_regs.sv */
// testbench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_ckg_cfg_regs
  import ckg_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic frame_start, frame_read, frame_stop, rx_valid, tx_req, rx_ack_r;
  logic tx_valid_r, memory_programmed, memory_write_lock;
  logic first_loop_spread_enable, third_loop_source_select;
  logic third_loop_predivide_by_one, third_loop_predivide_by_two;
  logic ref_divider_ok_r, fb_divider_ok_r, out_divider_three_source;
  logic first_loop_ref_doubler, first_loop_channel_two_enable;
  logic first_loop_extra_pole_enable;
  logic [3:0]  out_divider_five_code;
  logic [4:0]  pump_weight_r, pump_divisor_r, third_loop_iref_ua_r;
  logic [5:0]  third_loop_ref_divider, out_divider_five_ratio_r;
  logic [7:0]  rx_byte, tx_byte_r, bus_addr_r, variant_code;
  logic [7:0]  first_loop_iref_tenth_ua_r;
  logic [10:0] third_loop_fb_divider, filter_r_total_r;
  logic [7:0]  img [8];
  logic [7:0]  b [10];
  int          err_total = 0;
  int          checks_done = 0;

  always #10 clk = ~clk;

  ckg_cfg_regs dut (.clk, .nrst, .frame_start, .frame_read, .frame_stop,
    .rx_valid, .rx_byte, .rx_ack_r, .tx_req, .tx_valid_r, .tx_byte_r,
    .bus_addr_r, .memory_programmed, .memory_write_lock,
    .first_loop_spread_enable, .third_loop_source_select, .variant_code,
    .third_loop_predivide_by_one, .third_loop_predivide_by_two,
    .third_loop_ref_divider, .ref_divider_ok_r, .third_loop_fb_divider,
    .fb_divider_ok_r, .filter_r_total_r, .out_divider_three_source,
    .pump_weight_r, .pump_divisor_r, .third_loop_iref_ua_r,
    .first_loop_ref_doubler, .first_loop_iref_tenth_ua_r,
    .first_loop_channel_two_enable, .first_loop_extra_pole_enable,
    .out_divider_five_code, .out_divider_five_ratio_r);

  ckg_host_model host (.clk, .rx_ack_r, .tx_valid_r, .tx_byte_r,
    .frame_start, .frame_read, .frame_stop, .rx_valid, .rx_byte, .tx_req);

  task automatic report_and_stop();
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic cf(input string nm, input logic [10:0] e, g);
    checks_done++;
    if (e !== g) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cf

  task automatic cb(input string nm, input logic [7:0] e, g);
    checks_done++;
    if (e !== g) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cb

  task automatic check_all();
    logic [5:0] fa [4];
    logic [5:0] fb [4];
    fa = '{6'h01, 6'h02, 6'h04, 6'h05};
    fb = '{6'h01, 6'h03, 6'h05, 6'h0a};
    repeat (3) @(negedge clk);
    cf("addr", 8'hd0 | {img[0][6:5], 1'b0}, bus_addr_r);
    cf("prog", img[0][7], memory_programmed);
    cf("lock", img[0][0], memory_write_lock);
    cf("spread", img[0][4], first_loop_spread_enable);
    cf("src", img[0][2], third_loop_source_select);
    cf("variant", img[1], variant_code);
    cf("pre", img[3][7:6], {third_loop_predivide_by_one,
      third_loop_predivide_by_two});
    cf("refdiv", img[3][5:0], third_loop_ref_divider);
    cf("refok", img[3][5:0] >= 6'h03, ref_divider_ok_r);
    cf("fbdiv", {img[5][2:0], img[4]}, third_loop_fb_divider);
    cf("fbok", {img[5][2:0], img[4]} >= 11'h00c, fb_divider_ok_r);
    cf("filt", img[5][3] ? 11'h03c : 11'h3e8 * img[5][7] + 11'h1f4 *
      img[5][6] + 11'h0fa * img[5][5] + 11'h07d * img[5][4],
      filter_r_total_r);
    cf("d3src", img[6][7], out_divider_three_source);
    cf("pumpw", {1'b0, img[6][6:3]} << img[6][0], pump_weight_r);
    cf("pumpd", 5'h18 * img[6][2] + 5'h03 * img[6][1],
      pump_divisor_r);
    cf("iref3", img[6][0] ? 5'h14 : 5'h0a, third_loop_iref_ua_r);
    cf("dbl", img[7][7], first_loop_ref_doubler);
    cf("iref1", img[7][6] ? 8'hd8 : 8'h6c,
      first_loop_iref_tenth_ua_r);
    cf("ch2", img[7][5], first_loop_channel_two_enable);
    cf("pole", img[7][4], first_loop_extra_pole_enable);
    cf("d5code", img[7][3:0], out_divider_five_code);
    cf("d5", fa[img[7][3:2]] * fb[img[7][1:0]],
      out_divider_five_ratio_r);
  endtask : check_all

  // bytes past the count are refused and leave the bank alone
  task automatic wr(input logic st, input int nb);
    host.write_frame(st, st, b, nb);
    for (int k = 0; k < nb; k++) begin
      cf("ack", st && k < 2 + b[1], host.ack_seen[k]);
      if (st && k > 1 && k < 2 + b[1] && b[0] + k - 2 < 8)
        img[b[0] + k - 2] = b[k];
    end
    check_all();
  endtask : wr

  task automatic rd(input logic [7:0] idx, cnt, input int n);
    host.read_frame(idx, n);
    cb("count", cnt, host.rd[0]);
    for (int i = 1; i < n; i++)
      cb("byte", (idx + i - 1 < 8) ? img[idx + i - 1] : 8'h00,
        host.rd[i]);
  endtask : rd

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    img = '{8'h00, 8'h00, 8'h11, 8'h1a, 8'he0, 8'h11, 8'h6c, 8'h23};
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    check_all();
    rd(8'h00, CKG_COUNT_RESET, 10);
    b = '{8'h00, 8'h08, 8'h9d, 8'h5a, 8'ha5, 8'h82, 8'h0b, 8'ha8, 8'hd3,
          8'hdb};
    wr(1'b1, 10);
    rd(8'h00, 8'h08, 9);
    b = '{8'h03, 8'h03, 8'h43, 8'h0c, 8'h70, 8'h99, 8'h00, 8'h00, 8'h00,
          8'h00};
    wr(1'b1, 6);
    rd(8'h03, 8'h03, 5);
    for (int s = 0; s < 4; s++) begin
      b[0] = 8'h00;
      b[1] = 8'h01;
      b[2] = {1'b0, 2'(s), 5'h00};
      wr(1'b1, 3);
    end
    // third data byte lands on index 08h: acked but byte 0 stays intact
    b = '{8'h06, 8'h03, 8'h6c, 8'h23, 8'h77, 8'h00, 8'h00, 8'h00, 8'h00,
          8'h00};
    wr(1'b1, 5);
    for (int i = 0; i < 16; i++) begin
      b[0] = 8'h07;
      b[1] = 8'h01;
      b[2] = {4'(i), 4'(i)};
      wr(1'b1, 3);
    end
    b[0] = 8'h55;
    wr(1'b0, 1);
    report_and_stop();
  end
endmodule : test_ckg_cfg_regs
`default_nettype wire
